// ===== verilog/dpw_top.v
// What this block does
// - Mode comes from control bits 6..4; codes 3 to 7 pick modes 3 to 7.
// - Mode 3 counter runs the full 16-bit range from zero.
// - Mode 3 output A high while counter below duty_a, low after match.
// - Mode 3 output B high while counter below period_b, low after match.
// - Mode 3 outputs with nonzero duty_a or period_b go high together when the counter wraps.
// - Mode 4 drives port 1 bits 0 and 1, updated every PWM clock.
// - Mode 4 output A high duty_a cycles in every 65536.
// - Mode 4 output B high period_b cycles in every 65536.
// - Density modes spread high cycles with a first-order accumulator.
// - Mode 5 gives two independent 8-bit PWM outputs.
// - Mode 5 periods from period_b low/high, duties from duty_a low/high.
// - Both outputs share one PWM clock and one divider.
// - Mode 6 uses mode 4 density but on port 2 bits 5 and 6.
// - Mode 6 high cycles are high for the first half only at divide by 4, 16 or 64; at divide by 1 they stay high.
// - Mode 7 leaves port 2 bits 5 and 6 undriven.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "dpw_map.vh"
`default_nettype none
module dpw_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         port2_bit5_out,
    output reg         port2_bit5_oe,
    output reg         port2_bit6_out,
    output reg         port2_bit6_oe,
    output reg         port1_bit0_out,
    output reg         port1_bit0_oe,
    output reg         port1_bit1_out,
    output reg         port1_bit1_oe
);
    reg  [7:0]  ctrl_q;
    reg  [7:0]  duty_a_low_q;
    reg  [7:0]  duty_a_high_q;
    reg  [7:0]  period_b_low_q;
    reg  [7:0]  period_b_high_q;
    reg  [15:0] cmp_a_q;
    reg  [15:0] cmp_b_q;
    reg  [15:0] cnt_q;
    reg  [7:0]  cnt_b8_q;
    reg  [16:0] acc_a_q;
    reg  [16:0] acc_b_q;
    reg  [2:0]  mode_q;
    reg  [5:0]  div_cnt_q;
    reg         rz_half_q;
    reg         wave_out_a_q;
    reg         wave_out_b_q;
    reg  [31:0] rdata_d;
    reg         tick_d;
    reg  [5:0]  div_top;
    wire [2:0]  mode_sel    = ctrl_q[`DPW_MODE_MSB:`DPW_MODE_LSB];
    wire        mode_chg    = (mode_sel != mode_q);
    wire        acc_en      = psel && penable && pready;
    wire        wr_en       = acc_en && pwrite;
    wire        wrap16      = (cnt_q == `DPW_CNT_LAST);
    wire [15:0] duty_a      = {duty_a_high_q, duty_a_low_q};
    wire [15:0] period_b    = {period_b_high_q, period_b_low_q};
    wire [16:0] sum_a       = {1'b0, acc_a_q[15:0]} + {1'b0, cmp_a_q};
    wire [16:0] sum_b       = {1'b0, acc_b_q[15:0]} + {1'b0, cmp_b_q};
    wire        dual8_wrap_a = (cnt_q[7:0] >= period_b_low_q);
    wire        dual8_wrap_b = (cnt_b8_q >= period_b_high_q);

    // Common divider for both outputs; settings 1,4,16,64
    always @* begin
        case (ctrl_q[`DPW_DIV_MSB:`DPW_DIV_LSB])
            2'h0:    div_top = `DPW_DIV1_TOP;
            2'h1:    div_top = `DPW_DIV4_TOP;
            2'h2:    div_top = `DPW_DIV16_TOP;
            default: div_top = `DPW_DIV64_TOP;
        endcase
        tick_d = (div_cnt_q >= div_top);
    end

    always @* begin
        case (paddr)
            `DPW_ADDR_CTRL:      rdata_d = {24'h000000, ctrl_q};
            `DPW_ADDR_DUTY_A_LO: rdata_d = {24'h000000, duty_a_low_q};
            `DPW_ADDR_DUTY_A_HI: rdata_d = {24'h000000, duty_a_high_q};
            `DPW_ADDR_PER_B_LO:  rdata_d = {24'h000000, period_b_low_q};
            `DPW_ADDR_PER_B_HI:  rdata_d = {24'h000000, period_b_high_q};
            `DPW_ADDR_STATUS:    rdata_d = {cnt_q, 13'h0000, mode_q};
            default:             rdata_d = 32'h00000000;
        endcase
    end

    // APB slave: one wait state so read data comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready &&
                       (paddr > `DPW_ADDR_STATUS || paddr[1:0] != 2'h0);
            if (psel && penable && !pready && !pwrite)
                prdata <= rdata_d;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q          <= `DPW_CTRL_RST;
            duty_a_low_q    <= `DPW_BYTE_RST;
            duty_a_high_q   <= `DPW_BYTE_RST;
            period_b_low_q  <= `DPW_BYTE_RST;
            period_b_high_q <= `DPW_BYTE_RST;
        end else if (wr_en) begin
            case (paddr)
                `DPW_ADDR_CTRL:      ctrl_q          <= pwdata[7:0];
                `DPW_ADDR_DUTY_A_LO: duty_a_low_q    <= pwdata[7:0];
                `DPW_ADDR_DUTY_A_HI: duty_a_high_q   <= pwdata[7:0];
                `DPW_ADDR_PER_B_LO:  period_b_low_q  <= pwdata[7:0];
                `DPW_ADDR_PER_B_HI:  period_b_high_q <= pwdata[7:0];
                default:             ctrl_q          <= ctrl_q;
            endcase
        end
    end

    // Single divider serves both outputs; mode 5 adds a second 8-bit counter for B
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q       <= `DPW_MODE_RST;
            div_cnt_q    <= 6'h00;
            cnt_q        <= 16'h0000;
            cnt_b8_q     <= 8'h00;
            acc_a_q      <= 17'h00000;
            acc_b_q      <= 17'h00000;
            cmp_a_q      <= 16'h0000;
            cmp_b_q      <= 16'h0000;
            rz_half_q    <= 1'b0;
            wave_out_a_q <= 1'b0;
            wave_out_b_q <= 1'b0;
        end else if (mode_chg) begin
            // Fresh phase for the new mode
            mode_q       <= mode_sel;
            div_cnt_q    <= 6'h00;
            cnt_q        <= 16'h0000;
            cnt_b8_q     <= 8'h00;
            acc_a_q      <= 17'h00000;
            acc_b_q      <= 17'h00000;
            cmp_a_q      <= duty_a;
            cmp_b_q      <= period_b;
            rz_half_q    <= 1'b0;
            wave_out_a_q <= 1'b0;
            wave_out_b_q <= 1'b0;
        end else begin
            div_cnt_q <= tick_d ? 6'h00 : div_cnt_q + 6'h01;
            rz_half_q <= tick_d ? 1'b0 : (div_cnt_q >= (div_top >> 1));
            if (tick_d) begin
                case (mode_q)
                    `DPW_MODE_TWIN16: begin
                        cnt_q <= cnt_q + 16'h0001;
                        if (wrap16) begin
                            cmp_a_q      <= duty_a;
                            cmp_b_q      <= period_b;
                            wave_out_a_q <= (duty_a != 16'h0000);
                            wave_out_b_q <= (period_b != 16'h0000);
                        end else begin
                            wave_out_a_q <= (cnt_q + 16'h0001) < cmp_a_q;
                            wave_out_b_q <= (cnt_q + 16'h0001) < cmp_b_q;
                        end
                    end
                    `DPW_MODE_NRZ, `DPW_MODE_RZ: begin
                        // Carry out of the accumulator is the output bit
                        acc_a_q      <= sum_a;
                        acc_b_q      <= sum_b;
                        wave_out_a_q <= sum_a[16];
                        wave_out_b_q <= sum_b[16];
                        cnt_q        <= cnt_q + 16'h0001;
                        if (wrap16) begin
                            cmp_a_q <= duty_a;
                            cmp_b_q <= period_b;
                        end
                    end
                    `DPW_MODE_DUAL8: begin
                        // Two independent 8-bit counters, one per output
                        cnt_q    <= dual8_wrap_a ? 16'h0000
                                                 : cnt_q + 16'h0001;
                        cnt_b8_q <= dual8_wrap_b ? 8'h00 : cnt_b8_q + 8'h01;
                        wave_out_a_q <= dual8_wrap_a ?
                            (duty_a_low_q != 8'h00) :
                            ((cnt_q[7:0] + 8'h01) < duty_a_low_q);
                        wave_out_b_q <= dual8_wrap_b ?
                            (duty_a_high_q != 8'h00) :
                            ((cnt_b8_q + 8'h01) < duty_a_high_q);
                    end
                    default: begin
                        cnt_q        <= 16'h0000;
                        wave_out_a_q <= 1'b0;
                        wave_out_b_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Pin steering; mode 7 and modes 0 to 2 release the pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_bit5_out <= 1'b0;
            port2_bit5_oe  <= 1'b0;
            port2_bit6_out <= 1'b0;
            port2_bit6_oe  <= 1'b0;
            port1_bit0_out <= 1'b0;
            port1_bit0_oe  <= 1'b0;
            port1_bit1_out <= 1'b0;
            port1_bit1_oe  <= 1'b0;
        end else begin
            port1_bit0_oe  <= (mode_q == `DPW_MODE_NRZ);
            port1_bit1_oe  <= (mode_q == `DPW_MODE_NRZ);
            port1_bit0_out <= (mode_q == `DPW_MODE_NRZ) && wave_out_a_q;
            port1_bit1_out <= (mode_q == `DPW_MODE_NRZ) && wave_out_b_q;
            port2_bit5_oe  <= (mode_q == `DPW_MODE_TWIN16) ||
                              (mode_q == `DPW_MODE_DUAL8) ||
                              (mode_q == `DPW_MODE_RZ);
            port2_bit6_oe  <= (mode_q == `DPW_MODE_TWIN16) ||
                              (mode_q == `DPW_MODE_DUAL8) ||
                              (mode_q == `DPW_MODE_RZ);
            // Return to zero for the second half of each high PWM clock, except at divide by 1
            port2_bit5_out <= (mode_q == `DPW_MODE_RZ) ?
                              (wave_out_a_q && !rz_half_q) :
                              (mode_q != `DPW_MODE_NRZ && wave_out_a_q);
            port2_bit6_out <= (mode_q == `DPW_MODE_RZ) ?
                              (wave_out_b_q && !rz_half_q) :
                              (mode_q != `DPW_MODE_NRZ && wave_out_b_q);
        end
    end
endmodule // dpw_top
`default_nettype wire

// ===== verilog/dpw_map.vh
`ifndef DPW_MAP_VH
`define DPW_MAP_VH
// Register word byte addresses on the APB bus
`define DPW_ADDR_CTRL       12'h000
`define DPW_ADDR_DUTY_A_LO  12'h004
`define DPW_ADDR_DUTY_A_HI  12'h008
`define DPW_ADDR_PER_B_LO   12'h00C
`define DPW_ADDR_PER_B_HI   12'h010
`define DPW_ADDR_STATUS     12'h014
// Control word fields
`define DPW_MODE_MSB        6
`define DPW_MODE_LSB        4
`define DPW_DIV_MSB         3
`define DPW_DIV_LSB         2
// Mode codes
`define DPW_MODE_TWIN16     3'h3
`define DPW_MODE_NRZ        3'h4
`define DPW_MODE_DUAL8      3'h5
`define DPW_MODE_RZ         3'h6
`define DPW_MODE_OFF        3'h7
// Reset values
`define DPW_CTRL_RST        8'h00
`define DPW_BYTE_RST        8'h00
`define DPW_MODE_RST        3'h0
// Divider terminal counts for divide by 1, 4, 16 and 64
`define DPW_DIV1_TOP        6'h00
`define DPW_DIV4_TOP        6'h03
`define DPW_DIV16_TOP       6'h0F
`define DPW_DIV64_TOP       6'h3F
`define DPW_CNT_LAST        16'hFFFF
`endif

// ===== verification/dpw_load.sv
`default_nettype none
module dpw_load (
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic [3:0] drv,
    input  wire logic [3:0] en,
    output int              highs [4]
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins float up on the port pull-up, so only driven highs count
    wire logic [3:0] pin = (drv & en) | ~en;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            highs[i] <= clr ? 0 : highs[i] + int'(pin[i] & en[i]);
        end
    end
endmodule // dpw_load
`default_nettype wire

// ===== verification/dpw_properties.sv
`default_nettype none
module dpw_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        port2_bit5_out,
    input wire logic        port2_bit5_oe,
    input wire logic        port2_bit6_oe,
    input wire logic        port1_bit0_out,
    input wire logic        port1_bit0_oe,
    input wire logic        port1_bit1_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error outside answer");
    a_err_reads_zero: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0) else $error("refused read not zero");
    a_out_gated: assert property ((port2_bit5_out <= port2_bit5_oe)
        && (port1_bit0_out <= port1_bit0_oe)) else $error("undriven pin high");
    a_pins_exclusive: assert property (!(port2_bit5_oe && port1_bit0_oe))
        else $error("both pin groups driven");
    a_oe_paired: assert property (port2_bit5_oe == port2_bit6_oe
        && port1_bit0_oe == port1_bit1_oe) else $error("outputs not paired");
    a_reset_quiet: assert property (!$past(presetn) |-> !pready
        && !port2_bit5_oe && !port1_bit0_oe) else $error("busy after reset");
endmodule // dpw_properties
bind dpw_top dpw_properties chk (.*);
`default_nettype wire

// ===== verification/test_dpw_top.sv
`include "dpw_map.vh"
`default_nettype none
module test_dpw_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e;
    logic [3:0]  wout, woe;
    int          highs [4];
    int          mismatches = 0, check_count = 0, n;
    dpw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port2_bit5_out(wout[0]), .port2_bit5_oe(woe[0]),
        .port2_bit6_out(wout[1]), .port2_bit6_oe(woe[1]),
        .port1_bit0_out(wout[2]), .port1_bit0_oe(woe[2]),
        .port1_bit1_out(wout[3]), .port1_bit1_oe(woe[3]));
    dpw_load load (.clk(pclk), .clr(clr), .drv(wout), .en(woe), .highs(highs));
    always #10 pclk = ~pclk;
    task wrap_up;
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk) penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 20) begin chk(n, 0); wrap_up; end
        // Idle edge so the next setup never reassigns psel in this step
        @(posedge pclk);
    endtask
    task tick(input int k); repeat (k) @(posedge pclk); endtask
    // Counts k edges; one extra edge lets the last count land
    task win(input int k); clr <= 1; tick(1); clr <= 0; tick(k + 1); endtask
    task setm(input logic [2:0] m, input logic [1:0] dv);
        apb(1, `DPW_ADDR_CTRL, {25'h0, m, dv, 2'b00});
        tick(3);
        apb(0, `DPW_ADDR_STATUS, 32'h0);
        chk(r[2:0], m);
    endtask
    task wvals(input logic [7:0] al, ah, bl, bh);
        apb(1, `DPW_ADDR_DUTY_A_LO, {24'h0, al});
        apb(1, `DPW_ADDR_DUTY_A_HI, {24'h0, ah});
        apb(1, `DPW_ADDR_PER_B_LO, {24'h0, bl});
        apb(1, `DPW_ADDR_PER_B_HI, {24'h0, bh});
    endtask
    task t_reset;
        chk(woe, 4'h0);
        apb(0, `DPW_ADDR_CTRL, 32'h0); chk(r, 32'h0);
        apb(0, 12'h018, 32'h0); chk(r, 32'h0);
        chk(e, 1'b1);
        apb(1, 12'h006, 32'hFF); chk(e, 1'b1);
    endtask
    task t_twin16;
        wvals(8'h03, 8'h00, 8'h05, 8'h00);
        setm(3'h3, 2'h0);
        win(65536);
        chk(highs[0], 3);
        chk(highs[1], 5);
        chk(woe, 4'h3);
        n = 0;
        while (wout[0] !== 1'b0 && n < 70000) begin tick(1); n++; end
        while (wout[0] !== 1'b1 && n < 70000) begin tick(1); n++; end
        if (n >= 70000) begin chk(n, 0); wrap_up; end
        chk(wout[1], 1'b1);
    endtask
    task t_density;
        wvals(8'h00, 8'h40, 8'h00, 8'h80);
        setm(3'h4, 2'h0);
        win(64);
        chk(highs[2], 16);
        chk(highs[3], 32);
        chk(woe, 4'hC);
        setm(3'h7, 2'h0);
        wvals(8'h01, 8'h10, 8'h01, 8'h01);
        setm(3'h4, 2'h0);
        win(4096);
        chk(highs[2] >= 256 && highs[2] <= 257, 1);
        chk(highs[3] >= 16 && highs[3] <= 17, 1);
        setm(3'h7, 2'h0);
        wvals(8'h00, 8'h40, 8'h00, 8'h80);
        setm(3'h6, 2'h1);
        win(1024);
        chk(highs[0] >= 126 && highs[0] <= 130, 1);
        chk(highs[1] >= 254 && highs[1] <= 258, 1);
        chk(woe, 4'h3);
    endtask
    task t_dual8;
        wvals(8'h01, 8'h04, 8'h03, 8'h07);
        setm(3'h5, 2'h0);
        win(64);
        chk(highs[0], 16);
        chk(highs[1], 32);
        setm(3'h7, 2'h0);
        tick(2);
        chk(woe, 4'h0);
    endtask
    initial begin
        tick(5);
        presetn <= 1;
        tick(1);
        t_reset;
        t_twin16;
        t_density;
        t_dual8;
        wrap_up;
    end
endmodule // test_dpw_top
`default_nettype wire
